// ---- cmd_decoder.sv ----
`timescale 1ns/10ps
module cmd_decoder #(
	parameter int          NSUB        = 16,
	parameter logic [23:0] BOARD_MODEL = 24'h000001, // arbitrary value
	parameter logic [23:0] FW_MODEL    = 24'h000002, // arbitrary value
	parameter logic [23:0] FW_REV      = 24'h000003  // arbitrary value
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata_r,
	output logic             pready_r,
	output logic             pslverr_r,
	// host memory master
	output logic             mem_req_r,
	output logic             mem_we_r,
	output logic [23:0]      mem_addr_r,
	output logic [31:0]      mem_wdata_r,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	// device controller
	output logic             dev_valid_r,
	output logic [7:0]       dev_op_r,
	output logic [23:0]      dev_addr_r,
	output logic [15:0]      dev_count_r,
	output logic [1:0]       dev_first_byte_r,
	output logic             dev_skip_r,
	output logic             dev_blk768_r,
	output logic             dev_continue_r,
	output logic             purge_r,
	input  wire logic        dev_ready,
	input  wire logic        dev_done,
	input  wire logic        dev_unit_check,
	input  wire logic        dev_len_err,
	input  wire logic [15:0] dev_residual
);
	localparam int IDX_W = (NSUB > 1) ? $clog2(NSUB) : 1;

	// ==========================================
	// elaboration check: subaddress index must fit the 8-bit field
	generate
		if (NSUB < 2 || NSUB > 256 || (NSUB & (NSUB - 1)) != 0) begin : g_bad
			$error("NSUB must be a power of two from 2 to 256");
		end
	endgenerate

	// ==========================================
	// state
	chan_pkg::state_t st_r;
	logic [23:0]      list_ptr_r;
	logic [7:0]       subaddr_r;
	logic [23:0]      stbuf_r;
	logic [31:0]      last_st_r;
	logic             done_r;
	logic [23:0]      ptr_r;
	logic [1:0]       cbits_r;
	logic [31:0]      w0_r;
	logic [31:0]      w1_r;
	logic [7:0]       cmd_r;
	logic             first_r;
	logic             prev_tic_r;
	logic             in_dc_r;
	logic [1:0]       idx_r;
	logic             comp_uc_r;
	logic             comp_il_r;
	logic [15:0]      comp_res_r;
	logic [31:0]      post_w2_r;
	logic [31:0]      fin_w2_r;
	logic             final_r;
	logic             pend_final_r;
	logic [7:0]       opt_r [NSUB];

	// ==========================================
	// descriptor fields
	wire [7:0]  op     = w0_r[31:24];
	wire [23:0] daddr  = w0_r[23:0];
	wire [15:0] cnt    = w1_r[15:0];
	wire [23:0] dalign = {daddr[23:2], 2'b00};
	wire [7:0]  eff_op = in_dc_r ? cmd_r : op;  // data chain keeps first command
	wire        is_tic = (op[3:0] == chan_pkg::OPN_BRANCH) && !(op >= chan_pkg::OP_RSV_LO
	                     && op <= chan_pkg::OP_RSV_HI);
	wire        is_inch = op == chan_pkg::OP_INCH;
	wire        is_opt  = op == chan_pkg::OP_OPTS;
	wire        is_id   = op == chan_pkg::OP_ID;
	wire        is_rsv  = op >= chan_pkg::OP_RSV_LO && op <= chan_pkg::OP_RSV_HI && !is_id;
	wire        e_wr    = eff_op[1:0] == chan_pkg::OPC_WRITE;
	wire        e_rd    = eff_op[1:0] == chan_pkg::OPC_READ;
	wire        e_ctl   = eff_op[1:0] == chan_pkg::OPC_CTL;
	wire        e_sns   = eff_op[3:0] == chan_pkg::OPN_SENSE;
	wire        need_cnt = e_wr || e_rd || e_sns;
	wire        e_legal  = need_cnt || e_ctl;
	wire        dec_go   = st_r == chan_pkg::S_DECODE && !is_tic && !in_dc_r;
	wire        tic_bad  = first_r || prev_tic_r;

	// completion decision on the current descriptor's flags
	wire fdc  = w1_r[chan_pkg::FL_DC];
	wire fcc  = w1_r[chan_pkg::FL_CC];
	wire fsil = w1_r[chan_pkg::FL_SIL];
	wire fpci = w1_r[chan_pkg::FL_PCI];
	wire brk  = comp_uc_r || (comp_il_r && (fdc || !fsil));
	wire [15:0] fin_flags = 16'h0000 | (16'h0001 << chan_pkg::ST_CE)
	                        | (16'h0001 << chan_pkg::ST_DE)
	                        | ({15'h0000, comp_uc_r} << chan_pkg::ST_UC)
	                        | ({15'h0000, comp_il_r} << chan_pkg::ST_IL);
	wire [15:0] pc_flags  = (16'h0001 << chan_pkg::ST_PC) | (16'h0001 << chan_pkg::ST_CE)
	                        | (16'h0001 << chan_pkg::ST_DE);
	wire [15:0] pci_flags = 16'h0001 << chan_pkg::ST_PCI;

	// ==========================================
	// option table read, byte pick by low address bits
	wire [IDX_W-1:0] sidx    = subaddr_r[IDX_W-1:0];
	wire [7:0]       opt_cur = opt_r[sidx];
	wire [7:0]       opt_byte = (daddr[1:0] == 2'h0) ? mem_rdata[31:24] :
	                            (daddr[1:0] == 2'h1) ? mem_rdata[23:16] :
	                            (daddr[1:0] == 2'h2) ? mem_rdata[15:8] : mem_rdata[7:0];
	wire             mem_done = mem_req_r && mem_ack;
	wire             opt_load = st_r == chan_pkg::S_OPT_RD && mem_done;

	// ==========================================
	// memory request source per state
	wire mem_state = st_r == chan_pkg::S_FETCH0 || st_r == chan_pkg::S_FETCH1 ||
	                 st_r == chan_pkg::S_OPT_RD || st_r == chan_pkg::S_ID_WR ||
	                 st_r == chan_pkg::S_POST0 || st_r == chan_pkg::S_POST1;
	wire [23:0] id_word = (idx_r == 2'h0) ? BOARD_MODEL : (idx_r == 2'h1) ? FW_MODEL : FW_REV;
	wire [23:0] rep_ptr = {ptr_r[23:2], cbits_r};
	wire [23:0] maddr_nxt =
		(st_r == chan_pkg::S_FETCH0) ? ptr_r :
		(st_r == chan_pkg::S_FETCH1) ? ptr_r + chan_pkg::WORD_STEP :
		(st_r == chan_pkg::S_OPT_RD) ? dalign :
		(st_r == chan_pkg::S_ID_WR) ? dalign + {20'h00000, idx_r, 2'b00} :
		(st_r == chan_pkg::S_POST0) ? stbuf_r : stbuf_r + chan_pkg::WORD_STEP;
	wire        mwe_nxt = st_r == chan_pkg::S_ID_WR || st_r == chan_pkg::S_POST0 ||
	                      st_r == chan_pkg::S_POST1;
	// identification state flags in the top byte stay zero
	wire [31:0] mwd_nxt = (st_r == chan_pkg::S_ID_WR) ? {8'h00, id_word} :
	                      (st_r == chan_pkg::S_POST0) ? {subaddr_r, rep_ptr} : post_w2_r;

	// request held until acknowledged, then dropped for one cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem_req_r   <= 1'b0;
			mem_we_r    <= 1'b0;
			mem_addr_r  <= 24'h000000;
			mem_wdata_r <= 32'h00000000;
		end else begin
			mem_req_r <= mem_state && !(mem_req_r && mem_ack);
			if (mem_state && !mem_req_r) begin
				mem_we_r    <= mwe_nxt;
				mem_addr_r  <= maddr_nxt;
				mem_wdata_r <= mwd_nxt;
			end
		end
	end

	// ==========================================
	// apb slave: one wait cycle so read data comes from a flop
	wire busy     = st_r != chan_pkg::S_IDLE;
	wire apb_acc  = psel && penable && !pready_r;
	wire wr_fire  = psel && penable && pready_r && pwrite;
	wire sel_ctrl = paddr == chan_pkg::REG_CTRL;
	wire sel_ptr  = paddr == chan_pkg::REG_LIST_PTR;
	wire sel_sub  = paddr == chan_pkg::REG_SUBADDR;
	wire sel_stb  = paddr == chan_pkg::REG_STBUF;
	wire sel_lst  = paddr == chan_pkg::REG_LAST_ST;
	wire hit      = sel_ctrl || sel_ptr || sel_sub || sel_stb || sel_lst;
	wire start    = wr_fire && sel_ctrl && pwdata[chan_pkg::CTRL_START] && !busy;
	wire done_set = st_r == chan_pkg::S_POST1 && mem_done && final_r && !pend_final_r;
	wire [31:0] rd_val = sel_ctrl ? {30'h0, done_r, busy} :
	                     sel_ptr ? {8'h00, list_ptr_r} :
	                     sel_sub ? {24'h000000, subaddr_r} :
	                     sel_stb ? {8'h00, stbuf_r} :
	                     sel_lst ? last_st_r : 32'h00000000;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			prdata_r   <= 32'h00000000;
			list_ptr_r <= 24'h000000;
			subaddr_r  <= 8'h00;
			done_r     <= 1'b0;
		end else begin
			pready_r  <= apb_acc;
			pslverr_r <= apb_acc && !hit;
			prdata_r  <= apb_acc ? rd_val : 32'h00000000;
			if (wr_fire && sel_ptr && !busy)
				list_ptr_r <= pwdata[23:0];
			if (wr_fire && sel_sub && !busy)
				subaddr_r <= pwdata[7:0];
			// completion wins over a clear in the same cycle
			if (done_set)
				done_r <= 1'b1;
			else if (wr_fire && sel_ctrl && pwdata[chan_pkg::CTRL_DONE])
				done_r <= 1'b0;
		end
	end

	// ==========================================
	// option table, all eight bits kept; only bits 5 and 7 act
	genvar gi;
	generate
		for (gi = 0; gi < NSUB; gi++) begin : g_opt
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst)
					opt_r[gi] <= chan_pkg::RST_OPT;
				else if (opt_load && sidx == IDX_W'(gi))
					opt_r[gi] <= opt_byte;
			end
		end
	endgenerate

	// ==========================================
	// list sequencer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= chan_pkg::S_IDLE;
			stbuf_r <= chan_pkg::RST_STBUF; // status lands at zero until set
			last_st_r <= 32'h00000000;
			ptr_r <= 24'h000000;
			cbits_r <= 2'h0;
			w0_r <= 32'h00000000;
			w1_r <= 32'h00000000;
			cmd_r <= 8'h00;
			first_r <= 1'b0;
			prev_tic_r <= 1'b0;
			in_dc_r <= 1'b0;
			idx_r <= 2'h0;
			comp_uc_r <= 1'b0;
			comp_il_r <= 1'b0;
			comp_res_r <= 16'h0000;
			post_w2_r <= 32'h00000000;
			fin_w2_r <= 32'h00000000;
			final_r <= 1'b0;
			pend_final_r <= 1'b0;
			dev_valid_r <= 1'b0;
			dev_op_r <= 8'h00;
			dev_addr_r <= 24'h000000;
			dev_count_r <= 16'h0000;
			dev_first_byte_r <= 2'h0;
			dev_skip_r <= 1'b0;
			dev_blk768_r <= 1'b0;
			dev_continue_r <= 1'b0;
			purge_r <= 1'b0;
		end else begin
			purge_r <= 1'b0;
			case (st_r)
			chan_pkg::S_IDLE: begin
				if (start) begin
					ptr_r <= {list_ptr_r[23:2], 2'b00};
					cbits_r <= list_ptr_r[1:0];
					first_r <= 1'b1;
					prev_tic_r <= 1'b0;
					in_dc_r <= 1'b0;
					pend_final_r <= 1'b0;
					st_r <= chan_pkg::S_FETCH0;
				end
			end
			chan_pkg::S_FETCH0: begin
				if (mem_done) begin
					w0_r <= mem_rdata;
					st_r <= chan_pkg::S_FETCH1;
				end
			end
			chan_pkg::S_FETCH1: begin
				if (mem_done) begin
					w1_r <= mem_rdata;
					ptr_r <= ptr_r + chan_pkg::DESC_STEP;
					st_r <= chan_pkg::S_DECODE;
				end
			end
			chan_pkg::S_DECODE: begin
				first_r <= 1'b0;
				prev_tic_r <= is_tic;
				comp_uc_r <= 1'b0;
				comp_il_r <= 1'b0;
				comp_res_r <= 16'h0000;
				final_r <= 1'b1;
				if (is_tic && tic_bad) begin
					post_w2_r <= {pc_flags, cnt};
					st_r <= chan_pkg::S_POST0;
				end else if (is_tic) begin
					// branch posts nothing
					ptr_r <= dalign;
					st_r <= chan_pkg::S_FETCH0;
				end else if (!in_dc_r && is_inch) begin
					stbuf_r <= dalign; // count ignored
					if (daddr == 24'h000000) begin
						post_w2_r <= {pc_flags, cnt};
						st_r <= chan_pkg::S_POST0;
					end else
						st_r <= chan_pkg::S_COMPLETE;
				end else if (!in_dc_r && is_opt) begin
					st_r <= chan_pkg::S_OPT_RD;
				end else if (!in_dc_r && is_id) begin
					idx_r <= 2'h0;
					st_r <= chan_pkg::S_ID_WR;
				end else if ((!in_dc_r && is_rsv) || !e_legal || (need_cnt && cnt == 16'h0000)) begin
					post_w2_r <= {pc_flags, cnt};
					st_r <= chan_pkg::S_POST0;
				end else begin
					// device control with zero count passes
					cmd_r <= eff_op;
					dev_valid_r <= 1'b1;
					dev_op_r <= eff_op; // modifiers untouched
					dev_addr_r <= daddr;
					dev_count_r <= cnt;
					dev_first_byte_r <= daddr[1:0];
					dev_skip_r <= w1_r[chan_pkg::FL_SKIP];
					dev_blk768_r <= e_rd && !opt_cur[chan_pkg::OPT_BLKKEEP];
					dev_continue_r <= in_dc_r;
					st_r <= chan_pkg::S_DEV_WAIT;
				end
			end
			chan_pkg::S_OPT_RD: begin
				if (mem_done) begin
					comp_res_r <= (cnt == 16'h0000) ? 16'h0000 : cnt - 16'h0001; // one byte
					st_r <= chan_pkg::S_COMPLETE;
				end
			end
			chan_pkg::S_ID_WR: begin
				if (mem_done) begin
					idx_r <= idx_r + 2'h1;
					if (idx_r == chan_pkg::ID_LAST)
						st_r <= chan_pkg::S_COMPLETE;
				end
			end
			chan_pkg::S_DEV_WAIT: begin
				if (dev_valid_r && dev_ready)
					dev_valid_r <= 1'b0;
				if (dev_done) begin
					comp_uc_r <= dev_unit_check;
					comp_il_r <= dev_len_err;
					comp_res_r <= dev_residual;
					// queue purge only when the option asks
					purge_r <= dev_unit_check && opt_cur[chan_pkg::OPT_PURGE];
					st_r <= chan_pkg::S_COMPLETE;
				end
			end
			chan_pkg::S_COMPLETE: begin
				in_dc_r <= fdc && !brk;
				fin_w2_r <= {fin_flags, comp_res_r};
				if (brk) begin
					post_w2_r <= {fin_flags, comp_res_r};
					final_r <= 1'b1;
					st_r <= chan_pkg::S_POST0;
				end else if (fpci) begin
					post_w2_r <= {pci_flags, 16'h0000};
					final_r <= 1'b0;
					pend_final_r <= !(fdc || fcc);
					st_r <= chan_pkg::S_POST0;
				end else if (fdc || fcc) begin
					st_r <= chan_pkg::S_FETCH0;
				end else begin
					post_w2_r <= {fin_flags, comp_res_r};
					final_r <= 1'b1;
					st_r <= chan_pkg::S_POST0;
				end
			end
			chan_pkg::S_POST0: begin
				if (mem_done)
					st_r <= chan_pkg::S_POST1;
			end
			chan_pkg::S_POST1: begin
				if (mem_done) begin
					if (pend_final_r) begin
						post_w2_r <= fin_w2_r;
						final_r <= 1'b1;
						pend_final_r <= 1'b0;
						st_r <= chan_pkg::S_POST0;
					end else if (final_r) begin
						last_st_r <= post_w2_r;
						st_r <= chan_pkg::S_IDLE;
					end else
						st_r <= chan_pkg::S_FETCH0;
				end
			end
			default: st_r <= chan_pkg::S_IDLE;
			endcase
		end
	end

	// ==========================================
	// checks
	a_fetch_word_aligned: assert property (@(posedge clk_sys) disable iff (rst)
		(mem_req_r && (st_r == chan_pkg::S_FETCH0 || st_r == chan_pkg::S_FETCH1))
		|-> mem_addr_r[1:0] == 2'h0)
		else $error("descriptor fetch not word aligned");
	a_post_keeps_cbits: assert property (@(posedge clk_sys) disable iff (rst)
		(mem_req_r && st_r == chan_pkg::S_POST0) |-> mem_wdata_r[1:0] == cbits_r)
		else $error("reported list pointer lost low bits");
	a_inch_sets_buf: assert property (@(posedge clk_sys) disable iff (rst)
		(dec_go && is_inch) |=> stbuf_r == {$past(daddr[23:2]), 2'b00})
		else $error("status buffer not aligned copy of address");
	a_inch_zero_check: assert property (@(posedge clk_sys) disable iff (rst)
		(dec_go && is_inch && daddr == 24'h000000)
		|=> st_r == chan_pkg::S_POST0 && post_w2_r[16 + chan_pkg::ST_PC])
		else $error("zero status address did not post check");
	a_zero_count_abort: assert property (@(posedge clk_sys) disable iff (rst)
		(st_r == chan_pkg::S_DECODE && !is_tic && need_cnt && cnt == 16'h0000)
		|=> post_w2_r[16 + chan_pkg::ST_PC] ##1 !dev_valid_r)
		else $error("zero count transfer not aborted");
	a_ctl_zero_ok: assert property (@(posedge clk_sys) disable iff (rst)
		(dec_go && e_ctl && !is_rsv && !is_id && cnt == 16'h0000)
		|=> dev_valid_r && dev_count_r == 16'h0000)
		else $error("zero count control refused");
	a_branch_target: assert property (@(posedge clk_sys) disable iff (rst)
		(st_r == chan_pkg::S_DECODE && is_tic && !tic_bad)
		|=> st_r == chan_pkg::S_FETCH0 ##1 mem_req_r && mem_addr_r == $past(ptr_r))
		else $error("branch did not fetch from its address");
	a_dev_op_forward: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(dev_valid_r) |-> dev_op_r == $past(eff_op) && dev_skip_r == w1_r[chan_pkg::FL_SKIP])
		else $error("device opcode or skip altered");
	a_pci_zero_count: assert property (@(posedge clk_sys) disable iff (rst)
		(st_r == chan_pkg::S_COMPLETE && !brk && fpci)
		|=> post_w2_r == {pci_flags, 16'h0000} && st_r == chan_pkg::S_POST0)
		else $error("interrupt status not zero count");
	a_purge_on_check: assert property (@(posedge clk_sys) disable iff (rst)
		(st_r == chan_pkg::S_DEV_WAIT && dev_done && dev_unit_check)
		|=> purge_r == $past(opt_cur[chan_pkg::OPT_PURGE]))
		else $error("purge does not follow option bit");
endmodule

// ---- chan_pkg.sv ----
// Overview of operation
// - descriptor: opcode, 24-bit address, flags, count
// - status pointer keeps initial low address bits
// - list addresses forced to word boundary
// - channel runs 00, F0, 80 itself
// - status buffer setup stores word-aligned address
// - zero status address posts check/end status
// - setup count ignored; status at zero until set
// - option bit 7 set: unit check purges queue
// - option bit 7 clear: queue kept on error
// - option bit 5 clear: 256 reads become 768
// - option bits 0-4, 6 reserved, no function
// - identification returns three words, flags zero
// - device opcode modifier bits forwarded untouched
// - zero count read/write/sense aborts with check
// - zero count device control is valid
// - list branch fetches next from data address
// - list branch raises no interrupt request
// - data address is physical, unmapped
// - low address bits pick first byte, msb first
// - data chain: next descriptor, first command kept
// - command chain: next descriptor, own command
// - length suppress keeps list, data chain breaks
// - skip flag suppresses memory data writes
// - interrupt flag posts zero-count status
package chan_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_LIST_PTR = 8'h04;
	localparam logic [7:0] REG_SUBADDR  = 8'h08;
	localparam logic [7:0] REG_STBUF    = 8'h0C;
	localparam logic [7:0] REG_LAST_ST  = 8'h10;
	localparam int         CTRL_START   = 0;
	localparam int         CTRL_DONE    = 1;
	localparam logic [23:0] RST_STBUF   = 24'h000000;
	localparam logic [7:0]  RST_OPT     = 8'h00;
	// ==========================================
	// operation codes
	localparam logic [7:0] OP_INCH    = 8'h00;
	localparam logic [7:0] OP_OPTS    = 8'hF0;
	localparam logic [7:0] OP_ID      = 8'h80;
	localparam logic [7:0] OP_RSV_LO  = 8'h70;
	localparam logic [7:0] OP_RSV_HI  = 8'h90;
	localparam logic [1:0] OPC_WRITE  = 2'h1;
	localparam logic [1:0] OPC_READ   = 2'h2;
	localparam logic [1:0] OPC_CTL    = 2'h3;
	localparam logic [3:0] OPN_SENSE  = 4'h4;
	localparam logic [3:0] OPN_BRANCH = 4'h8;
	// ==========================================
	// descriptor word two flag positions, option byte bits
	localparam int FL_DC   = 31;
	localparam int FL_CC   = 30;
	localparam int FL_SIL  = 29;
	localparam int FL_SKIP = 28;
	localparam int FL_PCI  = 27;
	localparam int OPT_PURGE   = 7;
	localparam int OPT_BLKKEEP = 5;
	// ==========================================
	// status flag positions within the 16-bit field
	localparam int ST_PCI = 14;
	localparam int ST_IL  = 13;
	localparam int ST_PC  = 12;
	localparam int ST_CE  = 7;
	localparam int ST_DE  = 6;
	localparam int ST_UC  = 5;
	localparam logic [23:0] DESC_STEP = 24'h000008;
	localparam logic [23:0] WORD_STEP = 24'h000004;
	localparam logic [1:0]  ID_LAST   = 2'h2;

	typedef enum logic [3:0] {
		S_IDLE, S_FETCH0, S_FETCH1, S_DECODE, S_OPT_RD, S_ID_WR,
		S_DEV_WAIT, S_COMPLETE, S_POST0, S_POST1
	} state_t;
endpackage

// ---- far_side_model.sv ----
`timescale 1ns/10ps
// ==========================================
// host memory holding command lists, plus a device controller stand-in
module far_side_model (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// memory port
	input  wire logic        mem_req_r,
	input  wire logic        mem_we_r,
	input  wire logic [23:0] mem_addr_r,
	input  wire logic [31:0] mem_wdata_r,
	output logic             mem_ack,
	output logic [31:0]      mem_rdata,
	// device port
	input  wire logic        dev_valid_r,
	output logic             dev_ready,
	output logic             dev_done
);
	logic [31:0] mem [0:255];
	logic [1:0]  wait_cnt;
	logic        pend;

	// slow answer on purpose; read data toggles outside the ack cycle so no stale word is seen
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem_ack   <= 1'b0;
			wait_cnt  <= 2'h0;
			mem_rdata <= 32'h5A5A5A5A;
		end else if (mem_req_r && !mem_ack && wait_cnt == 2'h2) begin
			mem_ack   <= 1'b1;
			wait_cnt  <= 2'h0;
			mem_rdata <= mem[mem_addr_r[9:2]];
			if (mem_we_r) begin
				mem[mem_addr_r[9:2]] <= mem_wdata_r;
			end
		end else begin
			mem_ack   <= 1'b0;
			wait_cnt  <= (mem_req_r && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
			mem_rdata <= ~mem_rdata;
		end
	end

	// device takes one descriptor, finishes it two cycles later
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dev_ready <= 1'b0;
			pend      <= 1'b0;
			dev_done  <= 1'b0;
		end else begin
			dev_ready <= dev_valid_r && !dev_ready;
			pend      <= dev_valid_r && dev_ready;
			dev_done  <= pend;
		end
	end
endmodule

// ---- io_command_doubleword_decoder_tb.sv ----
`timescale 1ns/10ps
module io_command_doubleword_decoder_tb;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata_r, mem_wdata_r, mem_rdata, rd;
	logic        pready_r, pslverr_r, mem_req_r, mem_we_r, mem_ack, er;
	logic        dev_valid_r, dev_skip_r, dev_blk768_r, dev_continue_r, purge_r;
	logic        dev_ready, dev_done;
	logic [23:0] mem_addr_r, dev_addr_r, last_addr;
	logic [7:0]  dev_op_r, last_op;
	logic [15:0] dev_count_r;
	logic [1:0]  dev_first_byte_r, last_fb;
	logic        last_blk;
	logic        uc = 1'b0;
	int          n_dev = 0;
	int          n_purge = 0;
	int          n_pci = 0;
	int          miscompares = 0;
	int          n_checks = 0;

	cmd_decoder dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
		.pready_r(pready_r), .pslverr_r(pslverr_r), .mem_req_r(mem_req_r),
		.mem_we_r(mem_we_r), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .dev_valid_r(dev_valid_r),
		.dev_op_r(dev_op_r), .dev_addr_r(dev_addr_r), .dev_count_r(dev_count_r),
		.dev_first_byte_r(dev_first_byte_r), .dev_skip_r(dev_skip_r),
		.dev_blk768_r(dev_blk768_r), .dev_continue_r(dev_continue_r), .purge_r(purge_r),
		.dev_ready(dev_ready), .dev_done(dev_done), .dev_unit_check(uc),
		.dev_len_err(1'b0), .dev_residual(16'h0000));
	far_side_model mdl (.clk_sys(clk_sys), .rst(rst), .mem_req_r(mem_req_r),
		.mem_we_r(mem_we_r), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .dev_valid_r(dev_valid_r),
		.dev_ready(dev_ready), .dev_done(dev_done));

	// 125 MHz clock
	always #4 clk_sys = ~clk_sys;

	// record every descriptor the device accepts
	always @(posedge clk_sys) begin
		if (dev_valid_r === 1'b1 && dev_ready === 1'b1) begin
			n_dev     = n_dev + 1;
			last_op   = dev_op_r;
			last_addr = dev_addr_r;
			last_fb   = dev_first_byte_r;
			last_blk  = dev_blk768_r;
		end
		if (purge_r === 1'b1)
			n_purge = n_purge + 1;
		// word two of a program interrupt posting: flag only, zero count
		if (mem_req_r === 1'b1 && mem_ack === 1'b1 && mem_we_r === 1'b1
			&& mem_wdata_r === 32'h40000000)
			n_pci = n_pci + 1;
	end

	// ==========================================
	// shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// apb cycle: request held until pready_r is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready_r !== 1'b1) @(posedge clk_sys);
		rd = prdata_r;
		er = pslverr_r;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic put(input logic [23:0] a, input logic [31:0] w0, input logic [31:0] w1);
		mdl.mem[a[9:2]]        = w0;
		mdl.mem[a[9:2] + 8'h1] = w1;
	endtask

	// start a list and wait for done, bounded by a poll count
	task automatic run_list(input logic [23:0] ptr);
		int n;
		n = 0;
		apb(1'b1, chan_pkg::REG_LIST_PTR, {8'h00, ptr});
		apb(1'b1, chan_pkg::REG_CTRL, 32'h00000001);
		do begin
			apb(1'b0, chan_pkg::REG_CTRL, 32'h00000000);
			n++;
		end while (rd[chan_pkg::CTRL_DONE] !== 1'b1 && n < 200);
		check({31'h0, rd[chan_pkg::CTRL_DONE]}, 32'h00000001);
		apb(1'b1, chan_pkg::REG_CTRL, 32'h00000002);
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs;
		apb(1'b0, chan_pkg::REG_STBUF, 32'h00000000);
		check(rd, 32'h00000000);
		apb(1'b0, 8'h14, 32'h00000000);
		check({31'h0, er}, 32'h00000001);
		apb(1'b1, chan_pkg::REG_SUBADDR, 32'h00000005);
		apb(1'b0, chan_pkg::REG_SUBADDR, 32'h00000000);
		check(rd, 32'h00000005);
		$display("test regs done");
	endtask

	// unaligned list pointer and status address; count must be ignored
	task automatic t_inch;
		put(24'h000100, {chan_pkg::OP_INCH, 24'h000207}, 32'h00001234);
		run_list(24'h000103);
		apb(1'b0, chan_pkg::REG_STBUF, 32'h00000000);
		check(rd, 32'h00000204);
		check(mdl.mem[8'h81], 32'h0500010B);
		$display("test inch done");
	endtask

	// zero status address and zero counts end with check status, nothing reaches the device
	task automatic t_zero;
		logic [23:0] p [4] = '{24'h000120, 24'h000140, 24'h000148, 24'h000150};
		int n0;
		put(24'h000120, {chan_pkg::OP_INCH, 24'h000000}, 32'h00000010);
		put(24'h000140, 32'h02000300, 32'h00000000);
		put(24'h000148, 32'h04000300, 32'h00000000);
		put(24'h000150, 32'h01000300, 32'h00000000);
		for (int i = 0; i < 4; i++) begin
			n0 = n_dev;
			run_list(p[i]);
			apb(1'b0, chan_pkg::REG_LAST_ST, 32'h00000000);
			check({16'h0, rd[31:16] & 16'h10C0}, 32'h000010C0);
			check(32'(n_dev - n0), 32'h00000000);
		end
		$display("test zero counts done");
	endtask

	// zero-count control, branch, then write with modifier bits and byte offset
	task automatic t_chain;
		int n0;
		put(24'h000160, 32'h13000000, 32'h40000000);
		put(24'h000168, 32'h18000180, 32'h00000000);
		put(24'h000180, 32'h25000301, 32'h00000010);
		n0 = n_dev;
		run_list(24'h000160);
		check(32'(n_dev - n0), 32'h00000002);
		check({24'h0, last_op}, 32'h00000025);
		check({8'h0, last_addr}, 32'h00000301);
		check({30'h0, last_fb}, 32'h00000001);
		$display("test chain done");
	endtask

	// block size widening until the option byte keeps it
	task automatic t_opts;
		mdl.mem[8'hC0] = 32'h20000000;
		put(24'h0001A0, 32'h02000310, 32'h00000100);
		run_list(24'h0001A0);
		check({31'h0, last_blk}, 32'h00000001);
		put(24'h0001B0, 32'hF0000300, 32'h40000001);
		put(24'h0001B8, 32'h02000310, 32'h00000100);
		run_list(24'h0001B0);
		check({31'h0, last_blk}, 32'h00000000);
		$display("test options done");
	endtask

	// unit check ends the list; queue purged only once the option asks for it
	task automatic t_purge;
		int n0;
		n0 = n_purge;
		uc <= 1'b1;
		run_list(24'h0001A0);
		check(32'(n_purge - n0), 32'h00000000);
		apb(1'b0, chan_pkg::REG_LAST_ST, 32'h00000000);
		check({16'h0, rd[31:16] & 16'h0020}, 32'h00000020);
		mdl.mem[8'hC0] = 32'hA0000000;
		run_list(24'h0001B0);
		check(32'(n_purge - n0), 32'h00000001);
		uc <= 1'b0;
		$display("test purge done");
	endtask

	// identification words, then a skipped data chain with a program interrupt
	task automatic t_id_chain;
		int n0;
		n0 = n_pci;
		for (int i = 0; i < 3; i++)
			mdl.mem[8'hD0 + 8'(i)] = 32'hFFFFFFFF;
		put(24'h0001C0, {chan_pkg::OP_ID, 24'h000340}, 32'h4000000C);
		put(24'h0001C8, 32'h06000320, 32'h98000008);
		put(24'h0001D0, 32'h01000330, 32'h10000004);
		run_list(24'h0001C0);
		check({8'h0, mdl.mem[8'hD0][31:24], mdl.mem[8'hD1][31:24],
			mdl.mem[8'hD2][31:24]}, 32'h00000000);
		check({24'h0, last_op}, 32'h00000006);
		check({14'h0, dev_continue_r, dev_skip_r, dev_count_r}, 32'h00030004);
		check(32'(n_pci - n0), 32'h00000001);
		$display("test id and chain done");
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_inch();
		t_zero();
		t_chain();
		t_opts();
		t_purge();
		t_id_chain();
		summarize();
	end

	// watchdog: the tests need well under a tenth of this span
	initial begin
		#400000;
		miscompares++;
		summarize();
	end
endmodule
